//--- pdct_pkg.sv
// package: register map, control fields and timing constants of the down counter timer
package pdct_pkg;
  // ****************************************
  // register indices
  // ****************************************
  localparam logic [4:0] OFS_CONTROL    = 5'h10;
  localparam logic [4:0] OFS_VECTOR     = 5'h11;
  localparam logic [4:0] OFS_RELOAD_PAD = 5'h12;
  localparam logic [4:0] OFS_RELOAD_HI  = 5'h13;
  localparam logic [4:0] OFS_RELOAD_MID = 5'h14;
  localparam logic [4:0] OFS_RELOAD_LO  = 5'h15;
  localparam logic [4:0] OFS_COUNT_PAD  = 5'h16;
  localparam logic [4:0] OFS_COUNT_HI   = 5'h17;
  localparam logic [4:0] OFS_COUNT_MID  = 5'h18;
  localparam logic [4:0] OFS_COUNT_LO   = 5'h19;
  localparam logic [4:0] OFS_STATUS     = 5'h1A;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTL_ENABLE_BIT   = 0;
  localparam int CTL_CLK_LO_BIT   = 1;
  localparam int CTL_ZD_BIT       = 4;
  localparam int CTL_PIN_LO_BIT   = 5;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hF7;
  localparam int STAT_ZERO_BIT    = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] VECTOR_RESET  = 8'h0F;
  localparam logic [4:0] PRESCALE_FULL = 5'h1F;
  localparam logic [4:0] PRESCALE_LAST = 5'h00;
  localparam logic [23:0] COUNT_ONE    = 24'h000001;

  // ****************************************
  // clock source selections
  // ****************************************
  localparam logic [1:0] CLK_SYS_PRE        = 2'h0;
  localparam logic [1:0] CLK_SYS_PRE_GATED  = 2'h1;
  localparam logic [1:0] CLK_EXT_PRE        = 2'h2;
  localparam logic [1:0] CLK_EXT_DIRECT     = 2'h3;

  // ****************************************
  // output pin functions (bits 7..5)
  // ****************************************
  localparam logic [2:0] PIN_PORT      = 3'h0;
  localparam logic [2:0] PIN_SQUARE    = 3'h2;
  localparam logic [2:0] PIN_IRQ_VEC   = 3'h5;
  localparam logic [2:0] PIN_IRQ_AUTO  = 3'h7;

  localparam int SYNC_STAGES = 3;

  // bus request carrier
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } pdct_bus_req_t;

  // bus answer carrier
  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } pdct_bus_rsp_t;
endpackage

//--- pdct_timer.sv
// module: 24-bit prescaled down counter timer with byte register access
`timescale 1ns/1ps
// Function
// - vector same for read and acknowledge
// - reset loads vector with 0F
// - three byte preload registers, read/write
// - null location 12 reads zero
// - preload access has no interlock
// - reset keeps preload and counter
// - count bytes read live, writes ignored
// - null below count high reads zero
// - zero flag set on 1-to-0 decrement
// - status read harmless, write one clears
// - halt holds count, prescaler 1F, flag zero
// - reset clears control, halts, frees pins
// - run clocks counter from selected source
// - counter from prescaler rollover or input
// - first prescaler rollover loads counter
// - first input edge loads counter
// - zero control picks reload or rollover
// - acknowledge answered only while requesting
// - interrupt pin low while flag set
// - system clock decrements prescaler each cycle
module pdct_timer (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire pdct_pkg::pdct_bus_req_t bus_req,
  input  wire logic                   timer_int_ack_in,
  input  wire logic                   ext_timer_input,
  output logic                        bus_transfer_ack,
  output logic [7:0]                  bus_rdata,
  output logic                        timer_output_pin,
  output logic                        timer_output_oe_n,
  output logic                        ack_pin_is_timer,
  output logic                        ext_pin_is_timer
);
  // ****************************************
  // state declarations
  // ****************************************
  typedef enum logic [1:0] {
    PDCT_HALT = 2'b01,
    PDCT_RUN  = 2'b10
  } pdct_state_t;

  pdct_state_t           state_reg;
  logic [7:0]            timer_control_reg;
  logic [7:0]            timer_vector_reg;
  logic [7:0]            reload_high;
  logic [7:0]            reload_mid;
  logic [7:0]            reload_low;
  logic [23:0]           count_reg;
  logic [4:0]            prescale_reg;
  logic                  zero_reached_flag;
  logic                  loaded_reg;
  logic                  square_reg;
  logic [pdct_pkg::SYNC_STAGES-1:0] ext_sync_reg;
  logic                  ext_level;
  logic                  ext_rise;
  logic                  run_next;
  logic                  pre_tick;
  logic                  count_tick;
  logic                  zero_event;
  logic                  irq_active;
  logic [1:0]            clk_sel;
  logic [2:0]            pin_sel;
  logic                  wr_stb;
  logic [7:0]            rd_mux;

  assign clk_sel = timer_control_reg[pdct_pkg::CTL_CLK_LO_BIT +: 2];
  assign pin_sel = timer_control_reg[pdct_pkg::CTL_PIN_LO_BIT +: 3];
  assign wr_stb  = bus_req.sel & bus_req.wr;

  // ****************************************
  // external input synchroniser
  // ****************************************
  // three stages, edge when two later agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_sync_reg <= '0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[pdct_pkg::SYNC_STAGES-2:0], ext_timer_input};
    end
  end

  logic ext_level_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_level_reg <= 1'b0;
    end else if (ext_sync_reg[1] == ext_sync_reg[2]) begin
      ext_level_reg <= ext_sync_reg[2];
    end
  end
  assign ext_level = ext_level_reg;
  assign ext_rise  = (ext_sync_reg[1] == ext_sync_reg[2]) & ext_sync_reg[2] & ~ext_level_reg;

  // ****************************************
  // run / halt decision and clock sources
  // ****************************************
  // enable bit, gated by input level in mode 1
  assign run_next = timer_control_reg[pdct_pkg::CTL_ENABLE_BIT] &
                    ((clk_sel != pdct_pkg::CLK_SYS_PRE_GATED) | ext_level);

  // system clock ticks prescaler every cycle
  always_comb begin
    case (clk_sel)
      pdct_pkg::CLK_SYS_PRE:       pre_tick = 1'b1;
      pdct_pkg::CLK_SYS_PRE_GATED: pre_tick = 1'b1;
      pdct_pkg::CLK_EXT_PRE:       pre_tick = ext_rise;
      default:                     pre_tick = 1'b0;
    endcase
  end

  // prescaler rollover or direct input edge
  assign count_tick = (state_reg == PDCT_RUN) &
                      ((clk_sel == pdct_pkg::CLK_EXT_DIRECT) ? ext_rise :
                       (pre_tick & (prescale_reg == pdct_pkg::PRESCALE_LAST)));

  assign zero_event = count_tick & loaded_reg & (count_reg == pdct_pkg::COUNT_ONE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= PDCT_HALT;
    end else begin
      case (state_reg)
        PDCT_HALT: if (run_next) state_reg <= PDCT_RUN;
        PDCT_RUN:  if (!run_next) state_reg <= PDCT_HALT;
        default:   state_reg <= PDCT_HALT;
      endcase
    end
  end

  // ****************************************
  // prescaler
  // ****************************************
  // halt forces prescaler to all ones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale_reg <= pdct_pkg::PRESCALE_FULL;
    end else if (state_reg != PDCT_RUN) begin
      prescale_reg <= pdct_pkg::PRESCALE_FULL;
    end else if (pre_tick && clk_sel != pdct_pkg::CLK_EXT_DIRECT) begin
      prescale_reg <= prescale_reg - 5'h01;
    end
  end

  // ****************************************
  // counter
  // ****************************************
  // counter has no reset term
  always_ff @(posedge clk) begin
    if (count_tick) begin
      // first tick after run loads preload
      // reload after zero unless rollover selected
      // all 24 bits in one cycle
      if (!loaded_reg ||
          (count_reg == 24'h000000 && !timer_control_reg[pdct_pkg::CTL_ZD_BIT])) begin
        count_reg <= {reload_high, reload_mid, reload_low};
      end else begin
        count_reg <= count_reg - 24'h000001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loaded_reg <= 1'b0;
    end else if (state_reg != PDCT_RUN) begin
      loaded_reg <= 1'b0;
    end else if (count_tick) begin
      loaded_reg <= 1'b1;
    end
  end

  // ****************************************
  // zero flag
  // ****************************************
  // set on 1 to 0 transition; set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_reached_flag <= 1'b0;
    end else if (state_reg != PDCT_RUN) begin
      zero_reached_flag <= 1'b0;
    end else if (zero_event) begin
      zero_reached_flag <= 1'b1;
    end else if (wr_stb && bus_req.addr == pdct_pkg::OFS_STATUS &&
                 bus_req.wdata[pdct_pkg::STAT_ZERO_BIT]) begin
      zero_reached_flag <= 1'b0;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // reset clears all control bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_control_reg <= pdct_pkg::CONTROL_RESET;
    end else if (wr_stb && bus_req.addr == pdct_pkg::OFS_CONTROL) begin
      timer_control_reg <= bus_req.wdata & pdct_pkg::CTL_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_vector_reg <= pdct_pkg::VECTOR_RESET;
    end else if (wr_stb && bus_req.addr == pdct_pkg::OFS_VECTOR) begin
      timer_vector_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_stb && bus_req.addr == pdct_pkg::OFS_RELOAD_HI) begin
      reload_high <= bus_req.wdata;
    end
    if (wr_stb && bus_req.addr == pdct_pkg::OFS_RELOAD_MID) begin
      reload_mid <= bus_req.wdata;
    end
    if (wr_stb && bus_req.addr == pdct_pkg::OFS_RELOAD_LO) begin
      reload_low <= bus_req.wdata;
    end
  end

  // ****************************************
  // read path and acknowledge
  // ****************************************
  // preload pad reads zero
  always_comb begin
    case (bus_req.addr)
      pdct_pkg::OFS_CONTROL:    rd_mux = timer_control_reg;
      pdct_pkg::OFS_VECTOR:     rd_mux = timer_vector_reg;
      pdct_pkg::OFS_RELOAD_HI:  rd_mux = reload_high;
      pdct_pkg::OFS_RELOAD_MID: rd_mux = reload_mid;
      pdct_pkg::OFS_RELOAD_LO:  rd_mux = reload_low;
      pdct_pkg::OFS_COUNT_HI:   rd_mux = count_reg[23:16];
      pdct_pkg::OFS_COUNT_MID:  rd_mux = count_reg[15:8];
      pdct_pkg::OFS_COUNT_LO:   rd_mux = count_reg[7:0];
      pdct_pkg::OFS_STATUS:     rd_mux = {7'h00, zero_reached_flag};
      default:                  rd_mux = 8'h00;
    endcase
  end

  assign irq_active = (pin_sel == pdct_pkg::PIN_IRQ_VEC) & zero_reached_flag;

  // same vector on read and acknowledge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_transfer_ack <= 1'b0;
      bus_rdata        <= 8'h00;
    end else if (timer_int_ack_in) begin
      bus_transfer_ack <= irq_active;
      bus_rdata        <= irq_active ? timer_vector_reg : 8'h00;
    end else begin
      bus_transfer_ack <= bus_req.sel;
      bus_rdata        <= (bus_req.sel && !bus_req.wr) ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // output pin
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      square_reg <= 1'b1;
    end else if (state_reg != PDCT_RUN) begin
      square_reg <= 1'b1;
    end else if (zero_event) begin
      square_reg <= ~square_reg;
    end
  end

  // square modes drive square_reg; interrupt modes low while flag set; else released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_output_pin  <= 1'b0;
      timer_output_oe_n <= 1'b1;
      ack_pin_is_timer  <= 1'b0;
      ext_pin_is_timer  <= 1'b0;
    end else begin
      case (pin_sel)
        pdct_pkg::PIN_SQUARE, 3'h3: begin
          timer_output_pin  <= square_reg;
          timer_output_oe_n <= 1'b0;
        end
        pdct_pkg::PIN_IRQ_VEC, pdct_pkg::PIN_IRQ_AUTO: begin
          timer_output_pin  <= 1'b0;
          timer_output_oe_n <= ~zero_reached_flag;
        end
        default: begin
          timer_output_pin  <= 1'b0;
          timer_output_oe_n <= 1'b1;
        end
      endcase
      ack_pin_is_timer <= pin_sel[2] & ~pin_sel[1];
      ext_pin_is_timer <= clk_sel != pdct_pkg::CLK_SYS_PRE;
    end
  end
endmodule

//--- pdct_timer_props.sv
// checker: port properties of the down counter timer
`timescale 1ns/1ps
module pdct_timer_props (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire pdct_pkg::pdct_bus_req_t bus_req,
  input wire logic                    timer_int_ack_in,
  input wire logic                    bus_transfer_ack,
  input wire logic [7:0]              bus_rdata,
  input wire logic                    timer_output_oe_n,
  input wire logic                    ack_pin_is_timer,
  input wire logic                    ext_pin_is_timer
);
  // ************
  // shadows
  // ************
  logic       rd_ok, wr_ok, ctl_seen_reg;
  logic [7:0] vec_reg;
  assign rd_ok = bus_req.sel && !timer_int_ack_in && !bus_req.wr;
  assign wr_ok = bus_req.sel && !timer_int_ack_in && bus_req.wr;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_reg      <= 8'h0F;
      ctl_seen_reg <= 1'b0;
    end else begin
      if (wr_ok && bus_req.addr == pdct_pkg::OFS_VECTOR) vec_reg <= bus_req.wdata;
      if (wr_ok && bus_req.addr == pdct_pkg::OFS_CONTROL) ctl_seen_reg <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_bus_ack; (rd_ok || wr_ok) |=> bus_transfer_ack; endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("access not acked");
  property p_idle_data; !bus_transfer_ack |-> bus_rdata == 8'h00; endproperty
  a_idle_data: assert property (p_idle_data) else $error("data without ack");
  property p_reload_pad; rd_ok && bus_req.addr == 5'h12 |=> bus_rdata == 8'h00; endproperty
  a_reload_pad: assert property (p_reload_pad) else $error("pad not zero");
  property p_count_pad; rd_ok && bus_req.addr == 5'h16 |=> bus_rdata == 8'h00; endproperty
  a_count_pad: assert property (p_count_pad) else $error("count pad not zero");
  property p_vec_rd; rd_ok && bus_req.addr == 5'h11 |=> bus_rdata == vec_reg; endproperty
  a_vec_rd: assert property (p_vec_rd) else $error("vector read wrong");
  property p_iack; timer_int_ack_in |=> bus_transfer_ack == (ack_pin_is_timer && !timer_output_oe_n); endproperty
  a_iack: assert property (p_iack) else $error("ack answer wrong");
  property p_iack_vec; timer_int_ack_in ##1 bus_transfer_ack |-> bus_rdata == vec_reg; endproperty
  a_iack_vec: assert property (p_iack_vec) else $error("ack vector wrong");
  property p_rst_pins; !ctl_seen_reg |-> !ext_pin_is_timer && !ack_pin_is_timer && timer_output_oe_n; endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not freed");
  property p_clr;
    wr_ok && ack_pin_is_timer && bus_req.addr == 5'h1A && bus_req.wdata[0]
      |-> ##[2:3] timer_output_oe_n;
  endproperty
  a_clr: assert property (p_clr) else $error("request not dropped");
  property p_halt; wr_ok && bus_req.addr == 5'h10 && bus_req.wdata[7:5] == 3'h5 && !bus_req.wdata[0] |-> ##[1:4] timer_output_oe_n; endproperty
  a_halt: assert property (p_halt) else $error("halt left request");
endmodule

//--- pdct_host.sv
// host model: bus master, interrupt acknowledge and timer input
`timescale 1ns/1ps
module pdct_host (
  input  wire logic               clk,
  output pdct_pkg::pdct_bus_req_t bus_req,
  output logic                    timer_int_ack_in,
  output logic                    ext_timer_input
);
  // ************
  // bus and pins
  // ************
  logic [8:0] exp_q[$];
  initial begin
    bus_req          = '0;
    timer_int_ack_in = 1'b0;
    ext_timer_input  = 1'b0;
  end
  task automatic drop();
    bus_req.sel   <= 1'b0;
    bus_req.wdata <= ~bus_req.wdata;
  endtask
  // queue: read flag and expected data
  task automatic xfer(input logic wr, input logic [4:0] addr, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{sel: 1'b1, wr: wr, addr: addr, wdata: d};
    exp_q.push_back({!wr, wr ? 8'h00 : d});
  endtask
  task automatic iack(input logic answer, input logic [7:0] vec);
    @(posedge clk);
    drop();
    timer_int_ack_in <= 1'b1;
    if (answer) exp_q.push_back({1'b1, vec});
    @(posedge clk);
    timer_int_ack_in <= 1'b0;
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      drop();
      ext_timer_input <= 1'b1;
      repeat (4) @(posedge clk);
      ext_timer_input <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
  // hold the timer input at a steady level
  task automatic level(input logic v);
    @(posedge clk);
    drop();
    ext_timer_input <= v;
  endtask
  task automatic pause(input int n);
    @(posedge clk);
    drop();
    repeat (n) @(posedge clk);
  endtask
endmodule

//--- tb.sv
// testbench: registers, acknowledge and counting of the timer
`timescale 1ns/1ps
module tb;
  logic                    clk, rst, bus_transfer_ack, timer_output_pin, timer_output_oe_n;
  logic                    timer_int_ack_in, ext_timer_input, ack_pin_is_timer, ext_pin_is_timer;
  pdct_pkg::pdct_bus_req_t bus_req;
  logic [7:0]              bus_rdata, vec;
  logic [8:0]              e, pins;
  logic [23:0]             pre;
  logic [4:0]              nul [3] = '{5'h12, 5'h16, 5'h1F};
  int                      fails, tests_run, cycles;
  pdct_timer u_pdct_timer (
    .clk               (clk),
    .rst               (rst),
    .bus_req           (bus_req),
    .timer_int_ack_in  (timer_int_ack_in),
    .ext_timer_input   (ext_timer_input),
    .bus_transfer_ack  (bus_transfer_ack),
    .bus_rdata         (bus_rdata),
    .timer_output_pin  (timer_output_pin),
    .timer_output_oe_n (timer_output_oe_n),
    .ack_pin_is_timer  (ack_pin_is_timer),
    .ext_pin_is_timer  (ext_pin_is_timer)
  );
  pdct_host u_pdct_host (
    .clk              (clk),
    .bus_req          (bus_req),
    .timer_int_ack_in (timer_int_ack_in),
    .ext_timer_input  (ext_timer_input)
  );
  // pin outputs packed for direct compares
  assign pins = {5'h00, timer_output_pin, timer_output_oe_n, ack_pin_is_timer, ext_pin_is_timer};
  // ************
  // checking
  // ************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] want, input string msg);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: %s %h not %h", $time, msg, seen, want);
    end
  endtask
  task automatic wrap_up();
    check(9'(u_pdct_host.exp_q.size()), 9'h000, "answers missing");
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (bus_transfer_ack === 1'b1) begin
      e = u_pdct_host.exp_q.size() > 0 ? u_pdct_host.exp_q.pop_front() : 9'h0FF;
      check({e[8], e[8] ? bus_rdata : 8'h00}, e, "bus answer");
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic ctl(input logic [7:0] d);
    u_pdct_host.xfer(1'b1, pdct_pkg::OFS_CONTROL, d);
  endtask
  task automatic stat(input logic [7:0] d);
    u_pdct_host.xfer(1'b0, pdct_pkg::OFS_STATUS, d);
  endtask
  task automatic rw3(input logic wr, input logic [4:0] base, input logic [23:0] v);
    for (int i = 0; i < 3; i++)
      u_pdct_host.xfer(wr, base + 5'(i), v[23 - 8 * i -: 8]);
  endtask
  initial begin
    rst       = 1'b1;
    fails     = 0;
    tests_run = 0;
    cycles    = 0;
    vec = 8'($urandom(32'h12E7));
    pre = 24'($urandom()) | 24'h000100;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    u_pdct_host.xfer(1'b0, pdct_pkg::OFS_VECTOR, 8'h0F);
    u_pdct_host.xfer(1'b0, pdct_pkg::OFS_CONTROL, 8'h00);
    u_pdct_host.xfer(1'b1, pdct_pkg::OFS_VECTOR, vec);
    u_pdct_host.xfer(1'b0, pdct_pkg::OFS_VECTOR, vec);
    rw3(1'b1, pdct_pkg::OFS_RELOAD_HI, pre);
    rw3(1'b0, pdct_pkg::OFS_RELOAD_HI, pre);
    foreach (nul[i]) begin
      u_pdct_host.xfer(1'b1, nul[i], 8'($urandom()));
      u_pdct_host.xfer(1'b0, nul[i], 8'h00);
    end
    ctl(8'hA7);
    u_pdct_host.pulse(4);
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, pre - 24'h000003);
    rw3(1'b1, pdct_pkg::OFS_COUNT_HI, ~pre);
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, pre - 24'h000003);
    ctl(8'hA6);
    u_pdct_host.pause(8);
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, pre - 24'h000003);
    rw3(1'b1, pdct_pkg::OFS_RELOAD_HI, 24'h000002);
    ctl(8'hA7);
    u_pdct_host.pulse(3);
    stat(8'h01);
    u_pdct_host.iack(1'b1, vec);
    ctl(8'hE7);
    u_pdct_host.iack(1'b0, vec);
    @(negedge clk);
    check(pins, 9'h001, "autovector pins");
    ctl(8'hA7);
    u_pdct_host.xfer(1'b1, pdct_pkg::OFS_STATUS, 8'hFE);
    stat(8'h01);
    u_pdct_host.pulse(1);
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, 24'h000002);
    u_pdct_host.xfer(1'b1, pdct_pkg::OFS_STATUS, 8'h01);
    stat(8'h00);
    u_pdct_host.iack(1'b0, vec);
    ctl(8'hB7);
    u_pdct_host.pulse(3);
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, 24'hFFFFFF);
    stat(8'h01);
    ctl(8'hB6);
    u_pdct_host.pause(4);
    stat(8'h00);
    ctl(8'hB7);
    u_pdct_host.pause(2);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, 24'hFFFFFF);
    rw3(1'b0, pdct_pkg::OFS_RELOAD_HI, 24'h000002);
    u_pdct_host.xfer(1'b0, pdct_pkg::OFS_CONTROL, 8'h00);
    ctl(8'hA1);
    u_pdct_host.pause(76);
    stat(8'h00);
    u_pdct_host.pause(30);
    stat(8'h01);
    u_pdct_host.iack(1'b1, 8'h0F);
    ctl(8'hA0);
    u_pdct_host.pause(6);
    stat(8'h00);
    ctl(8'hA3);
    u_pdct_host.pause(40);
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, 24'h000000);
    u_pdct_host.level(1'b1);
    u_pdct_host.pause(40);
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, 24'h000002);
    u_pdct_host.level(1'b0);
    u_pdct_host.pause(8);
    ctl(8'h67);
    u_pdct_host.pulse(1);
    @(negedge clk);
    check(pins, 9'h009, "square idle");
    u_pdct_host.pulse(2);
    @(negedge clk);
    check(pins, 9'h001, "square toggle");
    rw3(1'b1, pdct_pkg::OFS_RELOAD_HI, 24'h000005);
    ctl(8'h66);
    ctl(8'h85);
    u_pdct_host.pulse(31);
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, 24'h000000);
    u_pdct_host.pulse(1);
    rw3(1'b0, pdct_pkg::OFS_COUNT_HI, 24'h000005);
    @(negedge clk);
    check(pins, 9'h007, "released pins");
    u_pdct_host.iack(1'b0, vec);
    u_pdct_host.pause(4);
    wrap_up();
  end
endmodule
bind pdct_timer pdct_timer_props u_pdct_timer_props (
  .clk               (clk),
  .rst               (rst),
  .bus_req           (bus_req),
  .timer_int_ack_in  (timer_int_ack_in),
  .bus_transfer_ack  (bus_transfer_ack),
  .bus_rdata         (bus_rdata),
  .timer_output_oe_n (timer_output_oe_n),
  .ack_pin_is_timer  (ack_pin_is_timer),
  .ext_pin_is_timer  (ext_pin_is_timer)
);
